// ---- sdmr_buf_mem.sv ----
`default_nettype none
module sdmr_buf_mem
  import sdmr_pkg::*;
#(
  parameter int AW = 12
)
(
  input wire logic core_clk,
  sdmr_mem_if.mem  m
);
  logic [7:0] ram [0:(1<<AW)-1];

  always_ff @(posedge core_clk)
  begin
    if (m.wr_en)
      ram[m.wr_addr] <= m.wr_data;
  end

  // A read of the byte being written returns the new value.
  always_ff @(posedge core_clk)
  begin
    if (m.rd_en)
      m.rd_data <= (m.wr_en && m.wr_addr == m.rd_addr) ? m.wr_data
                                                         : ram[m.rd_addr];
  end
endmodule
`default_nettype wire

// ---- sdmr_cmd.sv ----
`default_nettype none
`include "sdmr_defines.svh"
// How it works
// [RULE_01] Receive diagnostic results returns four sense-format bytes, length ignored.
// [RULE_02] After receive diagnostic, commands are refused until a bus reset.
// [RULE_03] Send diagnostic with self-test set waits for the self-test to finish.
// [RULE_04] Initiator sets parameter list length to zero for a self-test.
// [RULE_05] Send diagnostic without self-test does nothing and ends good.
// [RULE_06] Initiator fetches self-test results by sense or receive diagnostic.
// [RULE_07] Running the self-test clears all extent reservations.
// [RULE_08] Prevent set locks the door button; prevent clear unlocks it.
// [RULE_09] Check-door set with prevent clear fails with key 05h, code 24h.
// [RULE_10] Check-door and prevent with button pushed fail with key 06h, 9Dh.
// [RULE_11] Prevent set on a stopped cartridge fails with key 05h, code 22h.
// [RULE_12] Lock ends on allow command, bus device reset or hard reset.
// [RULE_13] Read capacity sends eight bytes: last address then length, MSB first.
// [RULE_14] Without partial medium flag, last drive block returned; address zero.
// [RULE_15] With partial medium flag, last block before a cylinder boundary.
// [RULE_16] Extended read takes address from bytes 2-5 and count from 7-8.
// [RULE_17] A zero block count transfers nothing and completes good.
// [RULE_18] Extended read returns the latest written block contents.
// [RULE_19] Inhibit-transfer reads into the buffer but sends nothing out.
// [RULE_20] Unknown opcodes end in check condition with illegal request.
module sdmr_cmd
  import sdmr_pkg::*;
#(
  parameter int          NBLK_LOG2 = 4,
  parameter int          CYL_LOG2  = 2,
  parameter logic [31:0] LAST_LBA  = 32'h0000_000F,
  parameter logic [31:0] BLK_LEN   = 32'h0000_0100
)
(
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                bus_reset,
  input  wire logic                bus_dev_reset,
  input  wire logic                door_pushed,
  input  wire logic                cart_stopped,
  output logic                     st_start,
  input  wire logic                st_done,
  input  wire logic                st_fail,
  output logic                     resv_clear,
  output logic                     removal_locked,
  input  wire logic                med_wr_en,
  input  wire logic [NBLK_LOG2+7:0] med_wr_addr,
  input  wire logic [7:0]          med_wr_data,
  output logic                     din_valid,
  output logic [7:0]               din_data,
  output logic                     din_last,
  input  wire logic                din_ready
);
  localparam int AW = NBLK_LOG2 + 8;

  sdmr_state_e   state_q;
  logic [31:0]   cdb_q [0:2];
  logic          aw_have_q, w_have_q, start_q, done_q, diag_mode_q;
  logic [7:0]    awaddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;
  logic [7:0]    status_q, asc_q;
  logic [3:0]    key_q;
  logic [63:0]   sh_q;
  logic [23:0]   cnt_q;
  logic [AW-1:0] ptr_q;
  logic          src_mem_q, inhibit_q;

  sdmr_mem_if #(.AW(AW)) mif ();

  sdmr_buf_mem #(.AW(AW)) u_mem (
    .core_clk (core_clk),
    .m        (mif)
  );

  function automatic logic [7:0] cb(input int n);
    cb = cdb_q[n/4][8*(n%4) +: 8];
  endfunction

  function automatic logic cbit(input int n, input int b);
    cbit = cdb_q[n/4][8*(n%4)+b];
  endfunction

  function automatic logic known(input logic [7:0] a);
    if (a == `SDMR_OFS_CDB0 || a == `SDMR_OFS_CDB1)
      known = 1'b1;
    else if (a == `SDMR_OFS_CDB2 || a == `SDMR_OFS_CTRL)
      known = 1'b1;
    else if (a == `SDMR_OFS_STAT || a == `SDMR_OFS_SENSE)
      known = 1'b1;
    else
      known = 1'b0;
  endfunction

  // Write channel: address and data are taken in either order.
  logic       aw_hit, w_hit, wr_fire;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign aw_hit  = s_axi_awvalid && s_axi_awready;
  assign w_hit   = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (aw_have_q || aw_hit) && (w_have_q || w_hit);
  assign wa = aw_have_q ? awaddr_q : s_axi_awaddr;
  assign wd = w_have_q ? wdata_q : s_axi_wdata;
  assign ws = w_have_q ? wstrb_q : s_axi_wstrb;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= `SDMR_CDB_RST;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SDMR_RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known(wa) ? `SDMR_RESP_OKAY : `SDMR_RESP_SLVERR;
      end
      else
      begin
        if (aw_hit)
        begin
          aw_have_q <= 1'b1;
          awaddr_q  <= s_axi_awaddr;
        end
        if (w_hit)
        begin
          w_have_q <= 1'b1;
          wdata_q  <= s_axi_wdata;
          wstrb_q  <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Command block bytes, honouring byte strobes.
  for (genvar g = 0; g < 3; g++)
  begin : g_cdb
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
        cdb_q[g] <= `SDMR_CDB_RST;
      else if (wr_fire && wa == 8'(4 * g) && state_q == SDMR_IDLE)
      begin
        for (int b = 0; b < 4; b++)
          if (ws[b])
            cdb_q[g][8*b +: 8] <= wd[8*b +: 8];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      start_q <= 1'b0;
    else
      start_q <= wr_fire && wa == `SDMR_OFS_CTRL && ws[0]
                 && wd[`SDMR_BIT_START];
  end

  // Read channel: answer one cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SDMR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= known(s_axi_araddr) ? `SDMR_RESP_OKAY
                                          : `SDMR_RESP_SLVERR;
      if (s_axi_araddr == `SDMR_OFS_CDB0)
        s_axi_rdata <= cdb_q[0];
      else if (s_axi_araddr == `SDMR_OFS_CDB1)
        s_axi_rdata <= cdb_q[1];
      else if (s_axi_araddr == `SDMR_OFS_CDB2)
        s_axi_rdata <= cdb_q[2];
      else if (s_axi_araddr == `SDMR_OFS_STAT)
        s_axi_rdata <= {14'h0000, removal_locked, diag_mode_q, status_q,
                        6'h00, done_q, state_q != SDMR_IDLE};
      else if (s_axi_araddr == `SDMR_OFS_SENSE)
        s_axi_rdata <= {16'h0000, asc_q, 4'h0, key_q};
      else
        s_axi_rdata <= 32'h0000_0000;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Command fields.
  logic [7:0]  op;
  logic [31:0] lba, cap_lba;
  logic [15:0] blocks;
  logic        ex, prv, chk_door, lba_bad;
  always_comb
  begin
    op       = cb(0);
    lba      = {cb(2), cb(3), cb(4), cb(5)}; // RULE_16
    blocks   = {cb(7), cb(8)}; // RULE_16
    prv      = cbit(4, `SDMR_BIT_PREVENT);
    chk_door = cbit(5, `SDMR_BIT_CHK_DOOR);
  end
  assign ex     = state_q == SDMR_EXEC && !diag_mode_q;
  assign lba_bad = ({1'b0, lba} + 33'(blocks)) > ({1'b0, LAST_LBA} + 33'd1);
  // Without the flag the initiator supplies address zero. RULE_14
  always_comb
  begin
    cap_lba = LAST_LBA;
    if (cbit(8, `SDMR_BIT_PARTIAL) && (lba | ((32'd1 << CYL_LOG2) - 32'd1))
        < LAST_LBA)
      cap_lba = lba | ((32'd1 << CYL_LOG2) - 32'd1); // RULE_15
  end

  // Receive diagnostic locks out normal operation until bus reset.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      diag_mode_q <= 1'b0;
    else if (ex && op == `SDMR_OP_RCV_DIAG)
      diag_mode_q <= 1'b1; // RULE_02
    else if (bus_reset)
      diag_mode_q <= 1'b0; // RULE_02
  end

  // Door lock state.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      removal_locked <= 1'b0; // RULE_12
    else if (ex && op == `SDMR_OP_PREVENT)
    begin
      if (!prv)
        removal_locked <= chk_door ? removal_locked : 1'b0; // RULE_08
      else if (!cart_stopped && !(chk_door && door_pushed))
        removal_locked <= 1'b1; // RULE_08
    end
    else if (bus_dev_reset)
      removal_locked <= 1'b0; // RULE_12
  end

  assign mif.rd_en   = state_q == SDMR_FETCH && src_mem_q;
  assign mif.rd_addr = ptr_q;
  assign mif.wr_en   = med_wr_en;
  assign mif.wr_addr = med_wr_addr;
  assign mif.wr_data = med_wr_data;
  assign din_last    = din_valid && cnt_q == 24'h00_0001;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q    <= SDMR_IDLE;
      done_q     <= 1'b0;
      status_q   <= `SDMR_ST_GOOD;
      key_q      <= `SDMR_KEY_NONE;
      asc_q      <= `SDMR_ASC_NONE;
      sh_q       <= 64'h0000_0000_0000_0000;
      cnt_q      <= 24'h00_0000;
      ptr_q      <= '0;
      src_mem_q  <= 1'b0;
      inhibit_q  <= 1'b0;
      din_valid  <= 1'b0;
      din_data   <= 8'h00;
      st_start   <= 1'b0;
      resv_clear <= 1'b0;
    end
    else
    begin
      st_start   <= 1'b0;
      resv_clear <= 1'b0;
      case (state_q)
        SDMR_IDLE:
        begin
          if (start_q)
          begin
            done_q  <= 1'b0;
            state_q <= SDMR_EXEC;
          end
        end
        SDMR_EXEC:
        begin
          status_q  <= `SDMR_ST_GOOD;
          key_q     <= `SDMR_KEY_NONE;
          asc_q     <= `SDMR_ASC_NONE;
          src_mem_q <= 1'b0;
          inhibit_q <= 1'b0;
          state_q   <= SDMR_DONE;
          if (diag_mode_q)
          begin
            status_q <= `SDMR_ST_CHECK; // RULE_02
            key_q    <= `SDMR_KEY_NOT_READY;
          end
          else if (op == `SDMR_OP_RCV_DIAG)
          begin
            sh_q    <= {4'h0, key_q, 56'h0}; // RULE_01
            cnt_q   <= `SDMR_DIAG_BYTES; // RULE_01
            state_q <= SDMR_FETCH;
          end
          else if (op == `SDMR_OP_SEND_DIAG)
          begin
            // A nonzero parameter list length is not checked. RULE_04
            if (cbit(1, `SDMR_BIT_SELF_TEST))
            begin
              st_start <= 1'b1; // RULE_03
              state_q  <= SDMR_SELFTEST;
            end
          end
          else if (op == `SDMR_OP_PREVENT)
          begin
            if (prv && cart_stopped)
            begin
              status_q <= `SDMR_ST_CHECK; // RULE_11
              key_q    <= `SDMR_KEY_ILLEGAL;
              asc_q    <= `SDMR_ASC_BAD_FUNC;
            end
            else if (chk_door && !prv)
            begin
              status_q <= `SDMR_ST_CHECK; // RULE_09
              key_q    <= `SDMR_KEY_ILLEGAL;
              asc_q    <= `SDMR_ASC_BAD_FIELD;
            end
            else if (chk_door && door_pushed)
            begin
              status_q <= `SDMR_ST_CHECK; // RULE_10
              key_q    <= `SDMR_KEY_ATTN;
              asc_q    <= `SDMR_ASC_CART_CHG;
            end
          end
          else if (op == `SDMR_OP_RD_CAP)
          begin
            sh_q    <= {cap_lba, BLK_LEN}; // RULE_13
            cnt_q   <= `SDMR_CAP_BYTES;
            state_q <= SDMR_FETCH;
          end
          else if (op == `SDMR_OP_RD_EXT)
          begin
            if (blocks != 16'h0000 && lba_bad)
            begin
              status_q <= `SDMR_ST_CHECK;
              key_q    <= `SDMR_KEY_ILLEGAL;
              asc_q    <= `SDMR_ASC_BAD_LBA;
            end
            else if (blocks != 16'h0000) // RULE_17
            begin
              ptr_q     <= AW'({lba, 8'h00});
              cnt_q     <= {blocks, 8'h00};
              src_mem_q <= 1'b1;
              inhibit_q <= cbit(9, `SDMR_BIT_INHIBIT); // RULE_19
              state_q   <= SDMR_FETCH;
            end
          end
          else
          begin
            status_q <= `SDMR_ST_CHECK; // RULE_20
            key_q    <= `SDMR_KEY_ILLEGAL;
            asc_q    <= `SDMR_ASC_BAD_OP;
          end
        end
        SDMR_SELFTEST:
        begin
          if (st_done)
          begin
            resv_clear <= 1'b1; // RULE_07
            state_q    <= SDMR_DONE; // RULE_03
            if (st_fail)
            begin
              status_q <= `SDMR_ST_CHECK;
              key_q    <= `SDMR_KEY_HW;
              asc_q    <= `SDMR_ASC_SELFTEST;
            end
          end
        end
        SDMR_FETCH:
          state_q <= SDMR_LOAD;
        SDMR_LOAD:
        begin
          din_data  <= src_mem_q ? mif.rd_data : sh_q[63:56]; // RULE_18
          din_valid <= !inhibit_q; // RULE_19
          state_q   <= SDMR_SEND;
        end
        SDMR_SEND:
        begin
          if (!din_valid || din_ready)
          begin
            din_valid <= 1'b0;
            sh_q      <= {sh_q[55:0], 8'h00};
            ptr_q     <= ptr_q + AW'(1);
            cnt_q     <= cnt_q - 24'h00_0001;
            state_q   <= (cnt_q == 24'h00_0001) ? SDMR_DONE : SDMR_FETCH;
          end
        end
        SDMR_DONE:
        begin
          done_q  <= 1'b1;
          state_q <= SDMR_IDLE;
        end
        default:
          state_q <= SDMR_IDLE;
      endcase
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  AST_DIAG_FOUR: assert property (ex && op == `SDMR_OP_RCV_DIAG |=> // RULE_01
    cnt_q == `SDMR_DIAG_BYTES && !src_mem_q && state_q == SDMR_FETCH)
    else $error("diagnostic result is not four bytes");
  AST_DIAG_HOLD: assert property (diag_mode_q && !bus_reset |=> // RULE_02
    diag_mode_q) else $error("diagnostic mode left without bus reset");
  AST_ST_WAIT: assert property (state_q == SDMR_SELFTEST && !st_done // RULE_03
    |=> state_q == SDMR_SELFTEST && !done_q)
    else $error("completion before self-test finished");
  AST_NOOP: assert property (ex && op == `SDMR_OP_SEND_DIAG // RULE_05
    && !cbit(1, `SDMR_BIT_SELF_TEST) |=> state_q == SDMR_DONE
    && status_q == `SDMR_ST_GOOD) else $error("no-op diagnostic not good");
  AST_RESV: assert property (state_q == SDMR_SELFTEST && st_done // RULE_07
    |=> resv_clear ##1 !resv_clear) else $error("reservations not cleared");
  AST_DOOR_FIELD: assert property (ex && op == `SDMR_OP_PREVENT // RULE_09
    && chk_door && !prv |=> key_q == `SDMR_KEY_ILLEGAL
    && asc_q == `SDMR_ASC_BAD_FIELD)
    else $error("check-door without prevent not rejected");
  AST_DOOR: assert property (ex && op == `SDMR_OP_PREVENT // RULE_10
    && chk_door && prv && door_pushed && !cart_stopped
    |=> status_q == `SDMR_ST_CHECK
    && key_q == `SDMR_KEY_ATTN && asc_q == `SDMR_ASC_CART_CHG
    && $stable(removal_locked)) else $error("pushed door not reported");
  AST_STOPPED: assert property (ex && op == `SDMR_OP_PREVENT && prv // RULE_11
    && cart_stopped |=> asc_q == `SDMR_ASC_BAD_FUNC)
    else $error("prevent on stopped cartridge not rejected");
  AST_BDR: assert property (bus_dev_reset && !ex |=> !removal_locked) // RULE_12
    else $error("lock survived bus device reset");
  AST_ZERO: assert property (ex && op == `SDMR_OP_RD_EXT // RULE_17
    && blocks == 16'h0000 |=> state_q == SDMR_DONE
    && status_q == `SDMR_ST_GOOD ##1 !din_valid)
    else $error("zero-length read misbehaved");
  AST_INHIB: assert property (state_q == SDMR_LOAD && inhibit_q // RULE_19
    |=> !din_valid) else $error("inhibited read sent data");
  AST_BADOP: assert property (ex && !(op inside {`SDMR_OP_RCV_DIAG, // RULE_20
    `SDMR_OP_SEND_DIAG, `SDMR_OP_PREVENT, `SDMR_OP_RD_CAP, `SDMR_OP_RD_EXT})
    |=> status_q == `SDMR_ST_CHECK && key_q == `SDMR_KEY_ILLEGAL
    && asc_q == `SDMR_ASC_BAD_OP)
    else $error("unknown opcode accepted");
endmodule
`default_nettype wire

// ---- sdmr_defines.svh ----
`ifndef SDMR_DEFINES_SVH
`define SDMR_DEFINES_SVH
`define SDMR_OFS_CDB0      8'h00
`define SDMR_OFS_CDB1      8'h04
`define SDMR_OFS_CDB2      8'h08
`define SDMR_OFS_CTRL      8'h0C
`define SDMR_OFS_STAT      8'h10
`define SDMR_OFS_SENSE     8'h14
`define SDMR_OP_RCV_DIAG   8'h1C
`define SDMR_OP_SEND_DIAG  8'h1D
`define SDMR_OP_PREVENT    8'h1E
`define SDMR_OP_RD_CAP     8'h25
`define SDMR_OP_RD_EXT     8'h28
`define SDMR_ST_GOOD       8'h00
`define SDMR_ST_CHECK      8'h02
`define SDMR_KEY_NONE      4'h0
`define SDMR_KEY_NOT_READY 4'h2
`define SDMR_KEY_HW        4'h4
`define SDMR_KEY_ILLEGAL   4'h5
`define SDMR_KEY_ATTN      4'h6
`define SDMR_ASC_NONE      8'h00
`define SDMR_ASC_BAD_OP    8'h20
`define SDMR_ASC_BAD_LBA   8'h21
`define SDMR_ASC_BAD_FUNC  8'h22
`define SDMR_ASC_BAD_FIELD 8'h24
`define SDMR_ASC_SELFTEST  8'h42
`define SDMR_ASC_CART_CHG  8'h9D
`define SDMR_DIAG_BYTES    24'h00_0004
`define SDMR_CAP_BYTES     24'h00_0008
`define SDMR_BIT_SELF_TEST 2
`define SDMR_BIT_PREVENT   0
`define SDMR_BIT_CHK_DOOR  7
`define SDMR_BIT_PARTIAL   0
`define SDMR_BIT_INHIBIT   7
`define SDMR_BIT_START     0
`define SDMR_STAT_BUSY     0
`define SDMR_STAT_DONE     1
`define SDMR_STAT_DIAG     16
`define SDMR_STAT_LOCK     17
`define SDMR_RESP_OKAY     2'b00
`define SDMR_RESP_SLVERR   2'b10
`define SDMR_CDB_RST       32'h0000_0000
`endif

// ---- sdmr_far_model.sv ----
`default_nettype none
module sdmr_far_model
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       st_start,
  output logic            st_done,
  output logic            st_fail,
  input  wire logic       din_valid,
  input  wire logic [7:0] din_data,
  input  wire logic       din_last,
  output logic            din_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  int         n_last = 0;
  int         dly = 0;
  // The self-test engine ends a few cycles after each start.
  logic       fail_next = 1'b0;
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      dly <= 0;
    else if (st_start)
      dly <= 6;
    else if (dly != 0)
      dly <= dly - 1;
    st_done <= arst_n && (dly == 1);
  end
  assign st_fail = st_done && fail_next;
  // The initiator stalls every other cycle.
  always @(posedge core_clk or negedge arst_n)
  begin
    din_ready <= arst_n && !din_ready;
    if (arst_n && din_valid && din_ready)
    begin
      got.push_back(din_data);
      if (din_last)
        n_last <= n_last + 1;
    end
  end
endmodule
`default_nettype wire

// ---- sdmr_mem_if.sv ----
`default_nettype none
interface sdmr_mem_if #(parameter int AW = 12);
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [7:0]    rd_data;
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0]    wr_data;
  modport ctrl (output rd_en, rd_addr, wr_en, wr_addr, wr_data,
                input rd_data);
  modport mem (input rd_en, rd_addr, wr_en, wr_addr, wr_data,
               output rd_data);
endinterface
`default_nettype wire

// ---- sdmr_pkg.sv ----
`default_nettype none
package sdmr_pkg;
  typedef enum logic [2:0] {
    SDMR_IDLE     = 3'b000,
    SDMR_EXEC     = 3'b001,
    SDMR_SELFTEST = 3'b010,
    SDMR_FETCH    = 3'b011,
    SDMR_LOAD     = 3'b100,
    SDMR_SEND     = 3'b101,
    SDMR_DONE     = 3'b110
  } sdmr_state_e;
endpackage
`default_nettype wire

// ---- tb.sv ----
`default_nettype none
`include "sdmr_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] LAST = 32'h0000_000F;
  localparam logic [31:0] BLK  = 32'h0000_0100;
  logic        core_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, bus_reset;
  logic        bus_dev_reset, door_pushed, cart_stopped, st_start, st_done;
  logic        st_fail, resv_clear, removal_locked, med_wr_en, din_valid;
  logic        din_last, din_ready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, med_wr_data, din_data;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, st, sn;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [11:0] med_wr_addr;
  int          n_mismatch = 0, n_compared = 0, n_rc = 0, n_st = 0, k, b;
  sdmr_cmd #(.NBLK_LOG2(4), .CYL_LOG2(2), .LAST_LBA(LAST), .BLK_LEN(BLK))
    i_sdmr_cmd (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .bus_reset, .bus_dev_reset, .door_pushed,
    .cart_stopped, .st_start, .st_done, .st_fail, .resv_clear,
    .removal_locked, .med_wr_en, .med_wr_addr, .med_wr_data, .din_valid,
    .din_data, .din_last, .din_ready);
  sdmr_far_model i_sdmr_far_model (.core_clk, .arst_n, .st_start, .st_done,
    .st_fail, .din_valid, .din_data, .din_last, .din_ready);
  initial
  begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (resv_clear === 1'b1)
      n_rc <= n_rc + 1;
    if (st_start === 1'b1)
      n_st <= n_st + 1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fail_to;
    n_mismatch++;
    $display("mismatch at %0t: wait ran out", $time);
    complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 0;
      if (s_axi_bvalid === 1'b1)
      begin
        rsp = s_axi_bresp;
        return;
      end
    end
    fail_to();
  endtask
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 0;
      if (s_axi_rvalid === 1'b1)
      begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        return;
      end
    end
    fail_to();
  endtask
  task automatic cmd(input logic [31:0] w0, w1, w2);
    i_sdmr_far_model.got.delete();
    wr(`SDMR_OFS_CDB0, w0);
    wr(`SDMR_OFS_CDB1, w1);
    wr(`SDMR_OFS_CDB2, w2);
    wr(`SDMR_OFS_CTRL, 32'h0000_0001);
    for (int i = 0; i < 1000; i++)
    begin
      rdr(`SDMR_OFS_STAT);
      st = rd;
      if (rd[`SDMR_STAT_DONE] === 1'b1)
      begin
        rdr(`SDMR_OFS_SENSE);
        sn = rd;
        return;
      end
    end
    fail_to();
  endtask
  task automatic res(input logic [7:0] s, input logic [3:0] y, logic [7:0] c);
    chk(st[15:8], s);
    chk(sn[3:0], y);
    chk(sn[15:8], c);
  endtask
  task automatic cap(input logic [63:0] e);
    chk(i_sdmr_far_model.got.size(), 8);
    for (int i = 0; i < 8; i++)
      chk(i_sdmr_far_model.got[i], e[63-8*i -: 8]);
  endtask
  initial
  begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, bus_reset} = 0;
    {bus_dev_reset, door_pushed, cart_stopped, med_wr_en} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, med_wr_addr, med_wr_data} = 0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    repeat (3) @(posedge core_clk);
    arst_n <= 1;
    @(posedge core_clk);
    rdr(`SDMR_OFS_STAT);
    chk(rd, 0);
    wr(8'h40, 32'h0000_0001);
    chk(rsp, `SDMR_RESP_SLVERR);
    rdr(8'h40);
    chk(rsp, `SDMR_RESP_SLVERR);
    $display("test registers done");
    cmd(32'h0000_0012, 0, 0);
    res(8'h02, 4'h5, 8'h20);
    k = n_st;
    cmd(32'h0000_001D, 0, 0);
    res(8'h00, 4'h0, 8'h00);
    chk(n_st - k, 0);
    b = n_rc;
    cmd(32'h0000_041D, 0, 0);
    res(8'h00, 4'h0, 8'h00);
    chk(n_st - k, 1);
    chk(n_rc - b, 1);
    i_sdmr_far_model.fail_next <= 1'b1;
    cmd(32'h0000_041D, 0, 0);
    res(8'h02, 4'h4, 8'h42);
    i_sdmr_far_model.fail_next <= 1'b0;
    cmd(32'h0100_001C, 32'h0000_00FF, 0);
    chk(i_sdmr_far_model.got.size(), 4);
    for (int i = 0; i < 4; i++)
      chk(i_sdmr_far_model.got[i], (i == 0) ? 8'h04 : 8'h00);
    cmd(32'h0000_001D, 0, 0);
    res(8'h02, 4'h2, 8'h00);
    chk(st[`SDMR_STAT_DIAG], 1);
    bus_reset <= 1;
    @(posedge core_clk);
    bus_reset <= 0;
    cmd(32'h0000_001D, 0, 0);
    res(8'h00, 4'h0, 8'h00);
    $display("test diagnostics done");
    cmd(32'h0000_001E, 32'h0000_8000, 0);
    res(8'h02, 4'h5, 8'h24);
    cart_stopped <= 1;
    cmd(32'h0000_001E, 32'h0000_0001, 0);
    res(8'h02, 4'h5, 8'h22);
    cart_stopped <= 0;
    door_pushed <= 1;
    cmd(32'h0000_001E, 32'h0000_8001, 0);
    res(8'h02, 4'h6, 8'h9D);
    door_pushed <= 0;
    cmd(32'h0000_001E, 32'h0000_8001, 0);
    res(8'h00, 4'h0, 8'h00);
    chk(removal_locked, 1);
    bus_dev_reset <= 1;
    @(posedge core_clk);
    bus_dev_reset <= 0;
    @(posedge core_clk);
    chk(removal_locked, 0);
    cmd(32'h0000_001E, 32'h0000_0001, 0);
    chk(st[`SDMR_STAT_LOCK], 1);
    cmd(32'h0000_001E, 0, 0);
    chk(removal_locked, 0);
    $display("test removal done");
    k = i_sdmr_far_model.n_last;
    cmd(32'h0000_0025, 0, 0);
    cap({LAST, BLK});
    chk(i_sdmr_far_model.n_last - k, 1);
    cmd(32'h0000_0025, 32'h0000_0500, 32'h0000_0001);
    cap({32'h0000_0007, BLK});
    $display("test capacity done");
    for (int i = 0; i < 257; i++)
    begin
      @(posedge core_clk);
      med_wr_en <= 1;
      med_wr_addr <= {4'h2, i[7:0]};
      med_wr_data <= (i == 256) ? 8'hC3 : i[7:0] ^ 8'h5A;
    end
    @(posedge core_clk);
    med_wr_en <= 0;
    cmd(32'h0000_0028, 32'h0000_0200, 32'h0000_0001);
    res(8'h00, 4'h0, 8'h00);
    chk(i_sdmr_far_model.got.size(), 256);
    for (int i = 0; i < 256; i++)
      chk(i_sdmr_far_model.got[i], (i == 0) ? 8'hC3 : i ^ 8'h5A);
    cmd(32'h0000_0028, 32'h0000_0200, 0);
    res(8'h00, 4'h0, 8'h00);
    chk(i_sdmr_far_model.got.size(), 0);
    cmd(32'h0000_0028, 32'h0000_0200, 32'h0000_8001);
    res(8'h00, 4'h0, 8'h00);
    chk(i_sdmr_far_model.got.size(), 0);
    cmd(32'h0000_0028, 32'h0000_0F00, 32'h0000_0002);
    res(8'h02, 4'h5, 8'h21);
    $display("test read done");
    cmd(32'h0000_001E, 32'h0000_0001, 0);
    chk(removal_locked, 1);
    arst_n <= 0;
    @(posedge core_clk);
    chk(removal_locked, 0);
    arst_n <= 1;
    @(posedge core_clk);
    rdr(`SDMR_OFS_STAT);
    chk(rd, 0);
    $display("test hard reset done");
    complete_run();
  end
endmodule
`default_nettype wire
